// ### ams_apb_slave.sv
`timescale 1ns/1ns
`default_nettype none

`include "ams_regs.svh"

module ams_apb_slave (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic addr_ok,
    output logic pready,
    output logic pslverr,
    output ams_pkg::ams_access_t kind
);
    // ----------------------------------------
    // one wait state: read data is caught on the first access edge,
    // a write commits on the edge where the master sees pready
    // ----------------------------------------
    wire logic access_w;
    wire logic rd_w;
    wire logic wr_w;

    assign access_w = psel & penable;
    assign rd_w = access_w & ~pready & ~pwrite;
    assign wr_w = access_w & pready & pwrite;
    assign kind = rd_w ? ams_pkg::AMS_ACC_READ :
                  wr_w ? ams_pkg::AMS_ACC_WRITE : ams_pkg::AMS_ACC_NONE;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= `AMS_RST_BIT;
            pslverr <= `AMS_RST_BIT;
        end else if (ce) begin
            pready <= access_w & ~pready;
            pslverr <= access_w & ~pready & ~addr_ok;
        end
    end

endmodule : ams_apb_slave

`default_nettype wire

// ### ams_event_detect.sv
`timescale 1ns/1ns
`default_nettype none

`include "ams_regs.svh"

module ams_event_detect #(
    parameter int TIMER_W = `AMS_TIMER_W
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic [TIMER_W-1:0] timer_count,
    input wire logic [TIMER_W-1:0] timer_goal,
    input wire logic [`AMS_MIX_W-1:0] mix_result,
    input wire logic mix_valid,
    input wire logic play_running,
    input wire logic play_fifo_empty,
    input wire logic tick_48k,
    input wire logic record_running,
    input wire logic record_request,
    input wire logic codec_data_ready,
    output logic hit_set,
    output logic ovf_set,
    output logic unf_set,
    output logic rec_set,
    output logic play_set
);
    // ----------------------------------------
    // event conditions
    // ----------------------------------------
    wire logic eq_w;
    logic eq_q;

    assign eq_w = (timer_count == timer_goal);
    // only the arrival at the goal counts, so a cleared flag does not
    // refire while the counter sits on the goal
    assign hit_set = eq_w & ~eq_q;
    assign ovf_set = mix_valid & ($signed(mix_result) > `AMS_MIX_POS_LIMIT);
    assign unf_set = mix_valid & ($signed(mix_result) < `AMS_MIX_NEG_LIMIT);
    assign rec_set = record_running & record_request & ~codec_data_ready;
    assign play_set = play_running & play_fifo_empty & tick_48k;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eq_q <= `AMS_RST_EQ;
        end else if (ce) begin
            eq_q <= eq_w;
        end
    end

endmodule : ams_event_detect

`default_nettype wire

// ### ams_misc_status.sv
// Register access over APB was left to the implementer.
`timescale 1ns/1ns
`default_nettype none

`include "ams_regs.svh"

module ams_misc_status #(
    parameter int CHANNELS = `AMS_CHANNELS,
    parameter int TIMER_W = `AMS_TIMER_W
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`AMS_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [TIMER_W-1:0] sample_timer_counter,
    input wire logic [TIMER_W-1:0] sample_timer_goal,
    input wire logic [`AMS_MIX_W-1:0] mix_result,
    input wire logic mix_valid,
    input wire logic play_running,
    input wire logic play_fifo_empty,
    input wire logic sample_tick_48k,
    input wire logic record_running,
    input wire logic record_request,
    input wire logic codec_data_ready,
    input wire logic fm_timer_request,
    input wire logic midi_port_request,
    input wire logic legacy_sound_request,
    input wire logic [CHANNELS-1:0] envelope_channel_flags,
    input wire logic [CHANNELS-1:0] address_flags_bank_a,
    input wire logic [CHANNELS-1:0] address_flags_bank_b,
    output logic [`AMS_STEP_W-1:0] sample_step,
    output logic half_rate_playback,
    output logic [31:0] misc_status
);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // hardware set wins over a software clear in the same cycle
    function automatic logic sticky_next(
        input logic q,
        input logic set,
        input logic clr
    );
        sticky_next = set | (q & ~clr);
    endfunction : sticky_next

    function automatic logic hit(
        input logic [`AMS_ADDR_W-1:0] addr,
        input logic [`AMS_ADDR_W-1:0] off
    );
        hit = (addr == off);
    endfunction : hit

    // ----------------------------------------
    // bus handshake and decode
    // ----------------------------------------
    ams_pkg::ams_access_t kind;
    wire logic sel_gpio;
    wire logic sel_gctl;
    wire logic sel_step;
    wire logic sel_misc;
    wire logic addr_ok;
    wire logic rd_take;
    wire logic wr_take;
    wire logic wr_gpio;
    wire logic wr_gctl;
    wire logic wr_step;
    wire logic wr_misc;

    assign sel_gpio = hit(paddr, `AMS_OFF_GPIO);
    assign sel_gctl = hit(paddr, `AMS_OFF_GCTL);
    assign sel_step = hit(paddr, `AMS_OFF_STEP);
    assign sel_misc = hit(paddr, `AMS_OFF_MISC);
    assign addr_ok = sel_gpio | sel_gctl | sel_step | sel_misc;
    assign rd_take = (kind == ams_pkg::AMS_ACC_READ);
    assign wr_take = (kind == ams_pkg::AMS_ACC_WRITE);
    assign wr_gpio = wr_take & sel_gpio;
    assign wr_gctl = wr_take & sel_gctl;
    assign wr_step = wr_take & sel_step;
    assign wr_misc = wr_take & sel_misc;

    ams_apb_slave u_apb (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .addr_ok(addr_ok),
        .pready(pready),
        .pslverr(pslverr),
        .kind(kind)
    );

    // ----------------------------------------
    // event sources
    // ----------------------------------------
    wire logic hit_set;
    wire logic ovf_set;
    wire logic unf_set;
    wire logic rec_set;
    wire logic play_set;

    ams_event_detect #(
        .TIMER_W(TIMER_W)
    ) u_events (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .timer_count(sample_timer_counter),
        .timer_goal(sample_timer_goal),
        .mix_result(mix_result),
        .mix_valid(mix_valid),
        .play_running(play_running),
        .play_fifo_empty(play_fifo_empty),
        .tick_48k(sample_tick_48k),
        .record_running(record_running),
        .record_request(record_request),
        .codec_data_ready(codec_data_ready),
        .hit_set(hit_set),
        .ovf_set(ovf_set),
        .unf_set(unf_set),
        .rec_set(rec_set),
        .play_set(play_set)
    );

    // ----------------------------------------
    // codec gpio enable and status bits
    // ----------------------------------------
    logic [`AMS_GPIO_HI:`AMS_GPIO_LO] gpio_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gpio_q <= `AMS_RST_GPIO;
        end else if (ce && wr_gpio) begin
            gpio_q <= pwdata[`AMS_GPIO_HI:`AMS_GPIO_LO];
        end
    end

    // ----------------------------------------
    // global control enables
    // ----------------------------------------
    logic play_starved_enable_q;
    logic record_overflow_enable_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            play_starved_enable_q <= `AMS_RST_BIT;
            record_overflow_enable_q <= `AMS_RST_BIT;
        end else if (ce && wr_gctl) begin
            play_starved_enable_q <= pwdata[`AMS_GCTL_PLAY_EN];
            record_overflow_enable_q <= pwdata[`AMS_GCTL_REC_EN];
        end
    end

    // ----------------------------------------
    // legacy sample step
    // ----------------------------------------
    // one field serves both directions; the meaning (rate ratio or its
    // inverse) is up to the engine that reads it
    logic [`AMS_STEP_W-1:0] step_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_q <= `AMS_RST_STEP;
        end else if (ce && wr_step) begin
            step_q <= pwdata[`AMS_STEP_W-1:0];
        end
    end

    // ----------------------------------------
    // misc status: software-owned bits
    // ----------------------------------------
    logic sample_timer_irq_enable_q;
    logic fm_timer_irq_enable_q;
    logic half_rate_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample_timer_irq_enable_q <= `AMS_RST_BIT;
            fm_timer_irq_enable_q <= `AMS_RST_BIT;
            half_rate_q <= `AMS_RST_BIT;
        end else if (ce && wr_misc) begin
            sample_timer_irq_enable_q <= pwdata[`AMS_MISC_ST_EN];
            fm_timer_irq_enable_q <= pwdata[`AMS_MISC_FM_EN];
            half_rate_q <= pwdata[`AMS_MISC_HALF];
        end
    end

    // ----------------------------------------
    // misc status: sticky event flags
    // ----------------------------------------
    logic sample_timer_hit_q;
    logic mix_overflow_q;
    logic mix_underflow_q;
    logic record_fifo_overflow_q;
    logic play_fifo_starved_q;
    wire logic clr_hit;
    wire logic clr_ovf;
    wire logic clr_unf;
    wire logic clr_rec;
    wire logic clr_play;

    assign clr_hit = wr_misc & pwdata[`AMS_MISC_ST_HIT];
    assign clr_ovf = wr_misc & pwdata[`AMS_MISC_MIX_OVF];
    assign clr_unf = wr_misc & pwdata[`AMS_MISC_MIX_UNF];
    assign clr_rec = wr_misc & pwdata[`AMS_MISC_REC_OVF];
    assign clr_play = wr_misc & pwdata[`AMS_MISC_PLAY_STV];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample_timer_hit_q <= `AMS_RST_BIT;
            mix_overflow_q <= `AMS_RST_BIT;
            mix_underflow_q <= `AMS_RST_BIT;
            record_fifo_overflow_q <= `AMS_RST_BIT;
            play_fifo_starved_q <= `AMS_RST_BIT;
        end else if (ce) begin
            sample_timer_hit_q <= sticky_next(sample_timer_hit_q, hit_set, clr_hit);
            mix_overflow_q <= sticky_next(mix_overflow_q, ovf_set, clr_ovf);
            mix_underflow_q <= sticky_next(mix_underflow_q, unf_set, clr_unf);
            record_fifo_overflow_q <= sticky_next(record_fifo_overflow_q, rec_set, clr_rec);
            play_fifo_starved_q <= sticky_next(play_fifo_starved_q, play_set, clr_play);
        end
    end

    // ----------------------------------------
    // misc status: live derived bits
    // ----------------------------------------
    // these have no storage, so a write to their positions has nowhere to land
    wire logic codec_gpio_irq;
    wire logic sample_timer_interrupt;
    wire logic envelope_interrupt;
    wire logic address_interrupt;
    wire logic fm_timer_interrupt;
    wire logic midi_port_interrupt;
    wire logic legacy_sound_interrupt;
    wire logic record_overflow_interrupt;
    wire logic play_starved_interrupt;

    assign codec_gpio_irq = (gpio_q[1] & gpio_q[3]) | (gpio_q[2] & gpio_q[4]);
    assign sample_timer_interrupt = sample_timer_hit_q & sample_timer_irq_enable_q;
    assign envelope_interrupt = |envelope_channel_flags;
    assign address_interrupt = (|address_flags_bank_a) | (|address_flags_bank_b);
    assign fm_timer_interrupt = fm_timer_request & fm_timer_irq_enable_q;
    assign midi_port_interrupt = midi_port_request;
    assign legacy_sound_interrupt = legacy_sound_request;
    assign record_overflow_interrupt = record_overflow_enable_q & record_fifo_overflow_q;
    assign play_starved_interrupt = play_starved_enable_q & play_fifo_starved_q;

    // ----------------------------------------
    // read words
    // ----------------------------------------
    ams_pkg::ams_word_t misc_word;
    ams_pkg::ams_word_t gpio_word;
    ams_pkg::ams_word_t gctl_word;
    ams_pkg::ams_word_t step_word;
    ams_pkg::ams_word_t read_word;

    // reserved positions read zero
    assign misc_word = {
        7'h00,
        codec_gpio_irq,
        sample_timer_irq_enable_q,
        5'h00,
        fm_timer_irq_enable_q,
        half_rate_q,
        sample_timer_hit_q,
        3'h0,
        mix_overflow_q,
        mix_underflow_q,
        record_fifo_overflow_q,
        play_fifo_starved_q,
        sample_timer_interrupt,
        envelope_interrupt,
        address_interrupt,
        fm_timer_interrupt,
        midi_port_interrupt,
        legacy_sound_interrupt,
        record_overflow_interrupt,
        play_starved_interrupt
    };
    assign gpio_word = {27'h0000000, gpio_q, 1'h0};
    assign gctl_word = {20'h00000, play_starved_enable_q, record_overflow_enable_q, 10'h000};
    assign step_word = {16'h0000, step_q};
    assign read_word = sel_misc ? misc_word :
                       sel_step ? step_word :
                       sel_gctl ? gctl_word :
                       sel_gpio ? gpio_word : `AMS_RST_WORD;

    // ----------------------------------------
    // registered outputs
    // ----------------------------------------
    // prdata is caught on the same edge where pready rises, so the master sees a
    // stable word for the whole completing cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= `AMS_RST_WORD;
        end else if (ce && rd_take) begin
            prdata <= read_word;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            misc_status <= `AMS_RST_WORD;
        end else if (ce) begin
            misc_status <= misc_word;
        end
    end

    // the step value is passed on as written; in half-rate mode it is
    // software's job to program twice the full-rate step
    assign sample_step = step_q;
    assign half_rate_playback = half_rate_q;

endmodule : ams_misc_status

`default_nettype wire

// ### ams_misc_status_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "ams_regs.svh"
module ams_misc_status_bench;
    logic pclk = 1'h0, presetn = 1'h0, ce = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, misc_status, r;
    logic pready, pslverr, half_rate_playback, e;
    logic [15:0] sample_timer_counter = 16'h0, sample_timer_goal = 16'h0, sample_step;
    logic [19:0] mix_result = 20'h0;
    logic mix_valid = 1'h0, play_running = 1'h0, play_fifo_empty = 1'h0, sample_tick_48k = 1'h0;
    logic record_running = 1'h0, record_request = 1'h0, codec_data_ready = 1'h0;
    logic fm_timer_request = 1'h0, midi_port_request = 1'h0, legacy_sound_request = 1'h0;
    logic [31:0] envelope_channel_flags = 32'h0, address_flags_bank_a = 32'h0, address_flags_bank_b = 32'h0;
    int n_fail = 0, checks_done = 0;
    localparam logic [11:0] MISC = `AMS_OFF_MISC, STEP = `AMS_OFF_STEP, GCTL = `AMS_OFF_GCTL, GPIO = `AMS_OFF_GPIO;
    always #20 pclk = ~pclk;
    ams_misc_status ams_misc_status_i (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sample_timer_counter(sample_timer_counter), .sample_timer_goal(sample_timer_goal),
        .mix_result(mix_result), .mix_valid(mix_valid), .play_running(play_running),
        .play_fifo_empty(play_fifo_empty), .sample_tick_48k(sample_tick_48k), .record_running(record_running),
        .record_request(record_request), .codec_data_ready(codec_data_ready),
        .fm_timer_request(fm_timer_request), .midi_port_request(midi_port_request),
        .legacy_sound_request(legacy_sound_request), .envelope_channel_flags(envelope_channel_flags),
        .address_flags_bank_a(address_flags_bank_a), .address_flags_bank_b(address_flags_bank_b),
        .sample_step(sample_step), .half_rate_playback(half_rate_playback), .misc_status(misc_status));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task summarize;
        if (n_fail == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : summarize
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // request held until the edge that samples pready high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1);
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        chk("pready wait", n, 32'h2);
    endtask : apb
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0);
        chk("read data", r, exp);
    endtask : rdc
    task automatic mixp(input logic [19:0] v);
        @(posedge pclk) begin
            mix_result <= v;
            mix_valid <= 1'h1;
        end
        @(posedge pclk) mix_valid <= 1'h0;
    endtask : mixp
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_reset;
        rdc(MISC, 32'h0);
        rdc(STEP, 32'h0);
        rdc(GCTL, 32'h0);
        chk("misc out", misc_status, 32'h0);
    endtask : t_reset
    task t_step;
        apb(1'h1, STEP, 32'hffff_1800);
        rdc(STEP, 32'h0000_1800);
        chk("step out", {16'h0, sample_step}, 32'h0000_1800);
        apb(1'h1, MISC, 32'hffff_ffff);
        rdc(MISC, 32'h0083_0000);
        chk("half rate", {31'h0, half_rate_playback}, 32'h1);
        apb(1'h1, STEP, 32'h0000_3000);
        rdc(STEP, 32'h0000_3000);
        apb(1'h1, MISC, 32'h0);
        rdc(MISC, 32'h0);
    endtask : t_step
    task t_gpio;
        logic [31:0] gv [4];
        gv = '{32'h0000_000a, 32'h0000_0014, 32'h0000_0006, 32'h0000_0018};
        for (int i = 0; i < 4; i++) begin
            apb(1'h1, GPIO, gv[i]);
            rdc(GPIO, gv[i]);
            rdc(MISC, {7'h0, gv[i][1] & gv[i][3] | gv[i][2] & gv[i][4], 24'h0});
        end
        apb(1'h1, GPIO, 32'h0);
    endtask : t_gpio
    task t_timer;
        apb(1'h1, MISC, 32'h0080_0000);
        @(posedge pclk) sample_timer_goal <= 16'h0005;
        @(posedge pclk) sample_timer_counter <= 16'h0005;
        @(posedge pclk) sample_timer_counter <= 16'h0006;
        rdc(MISC, 32'h0080_8080);
        apb(1'h1, MISC, 32'h0);
        rdc(MISC, 32'h0000_8000);
        apb(1'h1, MISC, 32'h0000_8000);
        rdc(MISC, 32'h0);
    endtask : t_timer
    task t_mix;
        mixp(20'h07fff);
        mixp(20'hf8000);
        rdc(MISC, 32'h0);
        mixp(20'h08000);
        rdc(MISC, 32'h0000_0800);
        mixp(20'hf7fff);
        rdc(MISC, 32'h0000_0c00);
        apb(1'h1, MISC, 32'h0000_0800);
        rdc(MISC, 32'h0000_0400);
        apb(1'h1, MISC, 32'h0000_0400);
        rdc(MISC, 32'h0);
    endtask : t_mix
    task t_fifo;
        apb(1'h1, GCTL, 32'hffff_ffff);
        rdc(GCTL, 32'h0000_0c00);
        @(posedge pclk) begin
            record_running <= 1'h1;
            record_request <= 1'h1;
            codec_data_ready <= 1'h1;
        end
        rdc(MISC, 32'h0);
        @(posedge pclk) codec_data_ready <= 1'h0;
        @(posedge pclk) record_request <= 1'h0;
        @(posedge pclk) begin
            play_running <= 1'h1;
            play_fifo_empty <= 1'h1;
        end
        rdc(MISC, 32'h0000_0202);
        @(posedge pclk) sample_tick_48k <= 1'h1;
        @(posedge pclk) sample_tick_48k <= 1'h0;
        rdc(MISC, 32'h0000_0303);
        apb(1'h1, GCTL, 32'h0);
        rdc(MISC, 32'h0000_0300);
        apb(1'h1, MISC, 32'h0000_0300);
        rdc(MISC, 32'h0);
    endtask : t_fifo
    // an overflow strobe while frozen must not land; then a reset in mid-run
    task t_freeze;
        @(posedge pclk) ce <= 1'h0;
        mixp(20'h08000);
        @(posedge pclk) ce <= 1'h1;
        rdc(MISC, 32'h0);
        @(posedge pclk) presetn <= 1'h0;
        @(posedge pclk) presetn <= 1'h1;
        rdc(STEP, 32'h0);
        chk("misc out", misc_status, 32'h0);
    endtask : t_freeze
    task t_src;
        @(posedge pclk) address_flags_bank_a <= 32'h0000_0001;
        rdc(MISC, 32'h0000_0020);
        @(posedge pclk) begin
            address_flags_bank_a <= 32'h0;
            address_flags_bank_b <= 32'h8000_0000;
            envelope_channel_flags <= 32'h0001_0000;
            fm_timer_request <= 1'h1;
            midi_port_request <= 1'h1;
            legacy_sound_request <= 1'h1;
        end
        rdc(MISC, 32'h0000_006c);
        apb(1'h1, MISC, 32'h0002_00ff);
        rdc(MISC, 32'h0002_007c);
        // unmapped place answers with an error and reads zero
        apb(1'h1, 12'h0fc, 32'hffff_ffff);
        chk("write err", {31'h0, e}, 32'h1);
        apb(1'h0, 12'h0fc, 32'h0);
        chk("read err", {31'h0, e}, 32'h1);
        chk("unmapped data", r, 32'h0);
        rdc(MISC, 32'h0002_007c);
    endtask : t_src
    initial begin
        repeat (4000) @(posedge pclk);
        n_fail++;
        summarize();
    end
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        t_reset();
        t_step();
        t_gpio();
        t_timer();
        t_mix();
        t_fifo();
        t_freeze();
        t_src();
        summarize();
    end
endmodule : ams_misc_status_bench
`default_nettype wire

// ### ams_misc_status_props.sv
`timescale 1ns/1ns
`default_nettype none
`include "ams_regs.svh"
module ams_misc_status_props #(
    parameter int CHANNELS = 32,
    parameter int TIMER_W = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [`AMS_MIX_W-1:0] mix_result,
    input wire logic mix_valid,
    input wire logic fm_timer_request,
    input wire logic midi_port_request,
    input wire logic legacy_sound_request,
    input wire logic [CHANNELS-1:0] envelope_channel_flags,
    input wire logic [CHANNELS-1:0] address_flags_bank_a,
    input wire logic [CHANNELS-1:0] address_flags_bank_b,
    input wire logic [31:0] misc_status
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ----------------------------------------
    // handshake
    // ----------------------------------------
    sequence s_access; psel && penable && !pready && ce; endsequence
    sequence s_over; ce && mix_valid && ($signed(mix_result) > `AMS_MIX_POS_LIMIT); endsequence
    sequence s_under; ce && mix_valid && ($signed(mix_result) < `AMS_MIX_NEG_LIMIT); endsequence
    property p_one_wait; s_access |=> pready; endproperty
    property p_ready_pulse; pready && ce |=> !pready; endproperty
    property p_err_ready; pslverr |-> pready; endproperty
    // ----------------------------------------
    // status word, seen one cycle late on misc_status
    // ----------------------------------------
    property p_env; ce |=> misc_status[6] == $past(|envelope_channel_flags); endproperty
    property p_addr; ce |=> misc_status[5] == $past(|{address_flags_bank_a, address_flags_bank_b}); endproperty
    property p_fm; ce |=> misc_status[4] == ($past(fm_timer_request) && misc_status[17]); endproperty
    property p_legacy; ce |=> misc_status[3:2] == {$past(midi_port_request), $past(legacy_sound_request)}; endproperty
    property p_sample_timer_interrupt; misc_status[7] == (misc_status[15] && misc_status[23]); endproperty
    // flag lands at the event edge, the delayed copy one edge later
    property p_ovf; s_over |=> ##1 misc_status[11]; endproperty
    property p_unf; s_under |=> ##1 misc_status[10]; endproperty
    a_one_wait: assert property (p_one_wait) else $error("pready not raised after first access cycle");
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready held longer than one cycle");
    a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
    a_env: assert property (p_env) else $error("envelope summary bit wrong");
    a_addr: assert property (p_addr) else $error("address summary bit wrong");
    a_fm: assert property (p_fm) else $error("fm timer bit wrong");
    a_legacy: assert property (p_legacy) else $error("midi or legacy mirror wrong");
    a_sample_timer_interrupt: assert property (p_sample_timer_interrupt) else $error("sample timer interrupt wrong");
    a_ovf: assert property (p_ovf) else $error("overflow flag not set");
    a_unf: assert property (p_unf) else $error("underflow flag not set");
endmodule : ams_misc_status_props

bind ams_misc_status ams_misc_status_props #(.CHANNELS(CHANNELS), .TIMER_W(TIMER_W)) ams_misc_status_props_i (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pready(pready),
    .pslverr(pslverr), .mix_result(mix_result), .mix_valid(mix_valid), .fm_timer_request(fm_timer_request),
    .midi_port_request(midi_port_request), .legacy_sound_request(legacy_sound_request),
    .envelope_channel_flags(envelope_channel_flags), .address_flags_bank_a(address_flags_bank_a),
    .address_flags_bank_b(address_flags_bank_b), .misc_status(misc_status)
);
`default_nettype wire

// ### ams_pkg.sv
`default_nettype none

package ams_pkg;

    typedef enum logic [1:0] {
        AMS_ACC_NONE,
        AMS_ACC_READ,
        AMS_ACC_WRITE
    } ams_access_t;

    typedef logic [31:0] ams_word_t;

endpackage : ams_pkg

`default_nettype wire

// ### ams_regs.svh
`ifndef AMS_REGS_SVH
`define AMS_REGS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define AMS_ADDR_W 12
`define AMS_OFF_GPIO 12'h04c
`define AMS_OFF_GCTL 12'h0a0
`define AMS_OFF_STEP 12'h0ac
`define AMS_OFF_MISC 12'h0b0

// ----------------------------------------
// field positions
// ----------------------------------------
`define AMS_GPIO_LO 1
`define AMS_GPIO_HI 4
`define AMS_GCTL_PLAY_EN 11
`define AMS_GCTL_REC_EN 10
`define AMS_STEP_W 16
`define AMS_MISC_GPIO_IRQ 24
`define AMS_MISC_ST_EN 23
`define AMS_MISC_FM_EN 17
`define AMS_MISC_HALF 16
`define AMS_MISC_ST_HIT 15
`define AMS_MISC_MIX_OVF 11
`define AMS_MISC_MIX_UNF 10
`define AMS_MISC_REC_OVF 9
`define AMS_MISC_PLAY_STV 8

// ----------------------------------------
// reset values and limits
// ----------------------------------------
`define AMS_RST_BIT 1'h0
`define AMS_RST_EQ 1'h1
`define AMS_RST_GPIO 4'h0
`define AMS_RST_STEP 16'h0000
`define AMS_RST_WORD 32'h0000_0000
`define AMS_CHANNELS 32
`define AMS_TIMER_W 16
`define AMS_MIX_W 20
`define AMS_MIX_POS_LIMIT 20'sh07fff
`define AMS_MIX_NEG_LIMIT 20'shf8000

`endif
